// >>> hw/eau_defs.vh
`ifndef EAU_DEFS_VH
`define EAU_DEFS_VH

// Addressing modes presented by the decoder
`define EAU_M_DREG 4'h0
`define EAU_M_AREG 4'h1
`define EAU_M_IND 4'h2
`define EAU_M_POST 4'h3
`define EAU_M_PRE 4'h4
`define EAU_M_DISP 4'h5
`define EAU_M_INDEX 4'h6
`define EAU_M_ABSW 4'h7
`define EAU_M_ABSL 4'h8
`define EAU_M_PCDISP 4'h9
`define EAU_M_PCIDX 4'ha
`define EAU_M_IMM 4'hb
`define EAU_M_QUICK 4'hc
`define EAU_M_IMPL 4'hd

// Operand sizes
`define EAU_SZ_BYTE 2'h0
`define EAU_SZ_WORD 2'h1
`define EAU_SZ_LONG 2'h2
`define EAU_SZ_BAD 2'h3

// Implied register selections
`define EAU_I_STATUS 3'h0
`define EAU_I_USER_SP 3'h1
`define EAU_I_SUPV_SP 3'h2
`define EAU_I_PC 3'h3
`define EAU_I_VEC_BASE 3'h4
`define EAU_I_SRC_FC 3'h5
`define EAU_I_DST_FC 3'h6

// General register file indices
`define EAU_NREGS 17
`define EAU_AREG_BASE 2'b01
`define EAU_USER_SP_IDX 5'h0f
`define EAU_SUPV_SP_IDX 5'h10
`define EAU_SP_NUM 3'h7

// Status word layout and reset
`define EAU_SW_RST 16'h2700
`define EAU_SW_MASK 16'ha71f
`define EAU_SW_S 13
`define EAU_VEC_BASE_RST 32'h00000000
`define EAU_FC_RST 3'h0

// Increment steps
`define EAU_STEP_BYTE 3'h1
`define EAU_STEP_WORD 3'h2
`define EAU_STEP_LONG 3'h4

// Register bus map (byte addresses)
`define EAU_A_SW 8'h00
`define EAU_A_VEC_BASE 8'h04
`define EAU_A_SRC_FC 8'h08
`define EAU_A_DST_FC 8'h0c
`define EAU_A_LAST_ADDR 8'h10
`define EAU_A_STAT 8'h14
`define EAU_A_GPR 8'h80

// Bus responses
`define EAU_RESP_OKAY 2'h0
`define EAU_RESP_SLVERR 2'h2

`endif

// >>> hw/eau_regfile.v
`include "eau_defs.vh"

module eau_regfile (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Write port
	input wire we,
	input wire [4:0] wsel,
	input wire [1:0] wsize,
	input wire [31:0] wdata,
	// Read ports, registered data
	input wire [4:0] rsel_a,
	input wire [4:0] rsel_b,
	output reg [31:0] rdata_a,
	output reg [31:0] rdata_b
);

	reg [31:0] mem [0:`EAU_NREGS-1];
	reg [31:0] merged;
	integer i;

	// Data registers merge sub-widths; address registers sign-extend words, drop bytes
	always @*
	begin
		merged = mem[wsel];
		if (wsel < 5'h08)
		begin
			case (wsize)
				`EAU_SZ_BYTE: merged = {mem[wsel][31:8], wdata[7:0]};
				`EAU_SZ_WORD: merged = {mem[wsel][31:16], wdata[15:0]};
				default: merged = wdata;
			endcase
		end
		else
		begin
			case (wsize)
				`EAU_SZ_WORD: merged = {{16{wdata[15]}}, wdata[15:0]};
				`EAU_SZ_LONG: merged = wdata;
				default: merged = mem[wsel];
			endcase
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (i = 0; i < `EAU_NREGS; i = i + 1)
				mem[i] <= 32'h00000000;
			rdata_a <= 32'h00000000;
			rdata_b <= 32'h00000000;
		end
		else
		begin
			if (we)
				mem[wsel] <= merged;
			rdata_a <= mem[rsel_a];
			rdata_b <= mem[rsel_b];
		end
	end

endmodule // eau_regfile

// >>> hw/eau_agen.v
module eau_agen (
	// Address terms
	input wire [31:0] base,
	input wire [31:0] index,
	input wire [31:0] disp,
	// Sum, modulo 2^32
	output wire [31:0] sum
);

	assign sum = base + index + disp;

endmodule // eau_agen

// >>> hw/eau_unit.v
// Overview of operation
// - Seventeen 32-bit data, address, stack registers
// - Data registers take byte, word, long
// - Address registers take word and long only
// - Any data or address register may be index, address 7 the current stack
// - Status word: mask, flags, trace, supervisor
// - Vector base register locates vector table
// - Source and destination alternate function codes
// - Absolute address from one or two words
// - PC relative: PC plus sixteen-bit displacement
// - PC indexed: PC plus index plus byte displacement
// - Indirect is register, optionally plus displacement
// - Indexed indirect: register, index, byte displacement
// - Postincrement uses register, then adds size
// - Predecrement subtracts size, then uses it
// - Implied selects status, stack, PC, base, codes
// - Step 1/2/4; stack byte steps 2
`include "eau_defs.vh"

module eau_unit (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Decoder request
	input wire req_valid,
	output wire req_ready,
	input wire [3:0] req_mode,
	input wire [2:0] req_reg,
	input wire [1:0] req_size,
	input wire [3:0] req_xsel,
	input wire req_xlong,
	input wire [15:0] req_ext0,
	input wire [15:0] req_ext1,
	input wire [31:0] req_pc,
	input wire [2:0] req_quick,
	input wire [2:0] req_impl,
	// Result to bus interface
	output wire done,
	output wire is_mem,
	output wire bad_mode,
	output wire [31:0] effective_address,
	output wire [31:0] operand,
	// Control register view
	output wire [15:0] status_word,
	output wire [31:0] vector_table_base,
	output wire [2:0] source_alt_fn_code,
	output wire [2:0] dest_alt_fn_code,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);

	localparam ST_IDLE = 3'b001;
	localparam ST_RD = 3'b010;
	localparam ST_CALC = 3'b100;

	// Address register n, with n = 7 the stack pointer of the current state
	function [4:0] map_a;
		input [2:0] n;
		input s;
		begin
			if (n == `EAU_SP_NUM)
				map_a = s ? `EAU_SUPV_SP_IDX : `EAU_USER_SP_IDX;
			else
				map_a = {`EAU_AREG_BASE, n};
		end
	endfunction

	function [4:0] map_x;
		input [3:0] x;
		input s;
		map_x = x[3] ? map_a(x[2:0], s) : {2'b00, x[2:0]};
	endfunction

	function gpr_ok;
		input [7:0] a;
		gpr_ok = a[7] && (a[1:0] == 2'b00) && (a[6:2] < `EAU_NREGS);
	endfunction

	function [1:0] strb_size;
		input [3:0] s;
		case (s)
			4'h1: strb_size = `EAU_SZ_BYTE;
			4'h3: strb_size = `EAU_SZ_WORD;
			4'hf: strb_size = `EAU_SZ_LONG;
			default: strb_size = `EAU_SZ_BAD;
		endcase
	endfunction

	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg req_ready_r;
	reg [3:0] mode_r;
	reg [4:0] asel_r;
	reg [4:0] xsel_r;
	reg [1:0] size_r;
	reg sp_r;
	reg xlong_r;
	reg [15:0] ext0_r;
	reg [15:0] ext1_r;
	reg [31:0] pc_r;
	reg [2:0] quick_r;
	reg [2:0] impl_r;
	reg done_r;
	reg is_mem_r;
	reg bad_mode_r;
	reg [31:0] eff_addr_r;
	reg [31:0] operand_r;
	reg [15:0] status_word_r;
	reg [31:0] vec_base_r;
	reg [2:0] src_fc_r;
	reg [2:0] dst_fc_r;
	reg awready_r;
	reg wready_r;
	reg aw_hold_r;
	reg w_hold_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bvalid_r;
	reg [1:0] bresp_r;
	reg arready_r;
	reg ar_hold_r;
	reg rd_wait_r;
	reg [7:0] araddr_r;
	reg rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0] rresp_r;
	reg [31:0] eff_addr_nxt;
	reg [31:0] opnd_nxt;
	reg mem_nxt;
	reg bad_nxt;
	reg [31:0] disp;
	reg [31:0] rd_nxt;
	reg [1:0] rresp_nxt;
	reg [1:0] bresp_nxt;

	wire [31:0] rdata_a;
	wire [31:0] rdata_b;
	wire [31:0] agen_sum;
	wire take = req_valid && req_ready_r;
	wire is_pc = (mode_r == `EAU_M_PCDISP) || (mode_r == `EAU_M_PCIDX);
	wire is_idx = (mode_r == `EAU_M_INDEX) || (mode_r == `EAU_M_PCIDX);
	wire is_post = (mode_r == `EAU_M_POST);
	wire is_pre = (mode_r == `EAU_M_PRE);
	wire fsm_wb = (st_r == ST_CALC) && (is_post || is_pre);
	wire [31:0] xval = xlong_r ? rdata_b : {{16{rdata_b[15]}}, rdata_b[15:0]};
	wire [31:0] disp_sixteen = {{16{ext0_r[15]}}, ext0_r};
	wire [31:0] disp_eight = {{24{ext0_r[7]}}, ext0_r[7:0]};
	wire [15:0] sw_mask = `EAU_SW_MASK;
	wire [2:0] step = (size_r == `EAU_SZ_BYTE) ? (sp_r ? `EAU_STEP_WORD : `EAU_STEP_BYTE) :
		(size_r == `EAU_SZ_WORD) ? `EAU_STEP_WORD : `EAU_STEP_LONG;
	wire [31:0] step32 = {29'h0, step};
	wire [1:0] wr_size = strb_size(wstrb_r);
	wire wr_gpr = gpr_ok(awaddr_r);
	wire aw_take = s_axi_awvalid && awready_r;
	wire w_take = s_axi_wvalid && wready_r;
	wire do_wr = aw_hold_r && w_hold_r && !bvalid_r && !fsm_wb;
	wire gpr_bad = (wr_size == `EAU_SZ_BAD) ||
		((awaddr_r[6:2] >= 5'h08) && (wr_size == `EAU_SZ_BYTE));
	wire rf_we = fsm_wb || (do_wr && wr_gpr && !gpr_bad);
	wire [4:0] rf_wsel = fsm_wb ? asel_r : awaddr_r[6:2];
	wire [1:0] rf_wsize = fsm_wb ? `EAU_SZ_LONG : wr_size;
	wire [31:0] rf_wdata = fsm_wb ? (is_post ? rdata_a + step32 : agen_sum) : wdata_r;
	wire rd_issue = ar_hold_r && !rd_wait_r && (st_r == ST_IDLE);
	wire [4:0] rf_rsel_a = (st_r == ST_RD) ? asel_r : araddr_r[6:2];
	wire ar_hold_nxt = rd_wait_r ? 1'b0 : (s_axi_arvalid && arready_r) ? 1'b1 : ar_hold_r;
	wire rvalid_nxt = rd_wait_r || (rvalid_r && !s_axi_rready);
	wire aw_hold_nxt = do_wr ? 1'b0 : aw_take ? 1'b1 : aw_hold_r;
	wire w_hold_nxt = do_wr ? 1'b0 : w_take ? 1'b1 : w_hold_r;
	wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);

	eau_regfile u_regfile (
		.clk(clk),
		.rst(rst),
		.we(rf_we),
		.wsel(rf_wsel),
		.wsize(rf_wsize),
		.wdata(rf_wdata),
		.rsel_a(rf_rsel_a),
		.rsel_b(xsel_r),
		.rdata_a(rdata_a),
		.rdata_b(rdata_b)
	);

	eau_agen u_agen (
		.base(is_pc ? pc_r : rdata_a),
		.index(is_idx ? xval : 32'h00000000),
		.disp(disp),
		.sum(agen_sum)
	);

	always @*
	begin
		case (mode_r)
			`EAU_M_DISP: disp = disp_sixteen;
			`EAU_M_PCDISP: disp = disp_sixteen;
			`EAU_M_INDEX: disp = disp_eight;
			`EAU_M_PCIDX: disp = disp_eight;
			`EAU_M_PRE: disp = 32'h00000000 - step32;
			default: disp = 32'h00000000;
		endcase
	end

	// Address or operand for the captured mode
	always @*
	begin
		eff_addr_nxt = eff_addr_r;
		opnd_nxt = operand_r;
		mem_nxt = 1'b1;
		bad_nxt = 1'b0;
		case (mode_r)
			`EAU_M_DREG, `EAU_M_AREG:
			begin
				opnd_nxt = rdata_a;
				mem_nxt = 1'b0;
			end
			`EAU_M_IND, `EAU_M_POST: eff_addr_nxt = rdata_a;
			`EAU_M_PRE, `EAU_M_DISP, `EAU_M_INDEX: eff_addr_nxt = agen_sum;
			`EAU_M_PCDISP, `EAU_M_PCIDX: eff_addr_nxt = agen_sum;
			`EAU_M_ABSW: eff_addr_nxt = disp_sixteen;
			`EAU_M_ABSL: eff_addr_nxt = {ext0_r, ext1_r};
			`EAU_M_IMM:
			begin
				mem_nxt = 1'b0;
				case (size_r)
					`EAU_SZ_BYTE: opnd_nxt = {24'h0, ext0_r[7:0]};
					`EAU_SZ_WORD: opnd_nxt = {16'h0, ext0_r};
					default: opnd_nxt = {ext0_r, ext1_r};
				endcase
			end
			`EAU_M_QUICK:
			begin
				mem_nxt = 1'b0;
				opnd_nxt = (quick_r == 3'h0) ? 32'h00000008 : {29'h0, quick_r};
			end
			`EAU_M_IMPL:
			begin
				mem_nxt = 1'b0;
				case (impl_r)
					`EAU_I_STATUS: opnd_nxt = {16'h0, status_word_r};
					`EAU_I_USER_SP, `EAU_I_SUPV_SP: opnd_nxt = rdata_a;
					`EAU_I_PC: opnd_nxt = pc_r;
					`EAU_I_VEC_BASE: opnd_nxt = vec_base_r;
					`EAU_I_SRC_FC: opnd_nxt = {29'h0, src_fc_r};
					`EAU_I_DST_FC: opnd_nxt = {29'h0, dst_fc_r};
					default: bad_nxt = 1'b1;
				endcase
			end
			default:
			begin
				mem_nxt = 1'b0;
				bad_nxt = 1'b1;
			end
		endcase
	end

	always @*
	begin
		case (st_r)
			ST_IDLE: st_nxt = take ? ST_RD : ST_IDLE;
			ST_RD: st_nxt = ST_CALC;
			ST_CALC: st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Capture request and produce result
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			req_ready_r <= 1'b0;
			mode_r <= `EAU_M_DREG;
			asel_r <= 5'h00;
			xsel_r <= 5'h00;
			size_r <= `EAU_SZ_BYTE;
			sp_r <= 1'b0;
			xlong_r <= 1'b0;
			ext0_r <= 16'h0000;
			ext1_r <= 16'h0000;
			pc_r <= 32'h00000000;
			quick_r <= 3'h0;
			impl_r <= 3'h0;
			done_r <= 1'b0;
			is_mem_r <= 1'b0;
			bad_mode_r <= 1'b0;
			eff_addr_r <= 32'h00000000;
			operand_r <= 32'h00000000;
		end
		else
		begin
			st_r <= st_nxt;
			req_ready_r <= (st_nxt == ST_IDLE) && !ar_hold_nxt;
			done_r <= (st_r == ST_CALC);
			if (take)
			begin
				mode_r <= req_mode;
				size_r <= req_size;
				sp_r <= (req_reg == `EAU_SP_NUM);
				xsel_r <= map_x(req_xsel, status_word_r[`EAU_SW_S]);
				xlong_r <= req_xlong;
				ext0_r <= req_ext0;
				ext1_r <= req_ext1;
				pc_r <= req_pc;
				quick_r <= req_quick;
				impl_r <= req_impl;
				if (req_mode == `EAU_M_DREG)
					asel_r <= {2'b00, req_reg};
				else if (req_mode == `EAU_M_IMPL)
					asel_r <= (req_impl == `EAU_I_SUPV_SP) ? `EAU_SUPV_SP_IDX : `EAU_USER_SP_IDX;
				else
					asel_r <= map_a(req_reg, status_word_r[`EAU_SW_S]);
			end
			if (st_r == ST_CALC)
			begin
				eff_addr_r <= eff_addr_nxt;
				operand_r <= opnd_nxt;
				is_mem_r <= mem_nxt;
				bad_mode_r <= bad_nxt;
			end
		end
	end

	// Bus write decode with strobes; unmapped addresses answer SLVERR
	always @*
	begin
		bresp_nxt = `EAU_RESP_OKAY;
		if (wr_gpr)
			bresp_nxt = gpr_bad ? `EAU_RESP_SLVERR : `EAU_RESP_OKAY;
		else if ((awaddr_r != `EAU_A_SW) && (awaddr_r != `EAU_A_VEC_BASE) &&
			(awaddr_r != `EAU_A_SRC_FC) && (awaddr_r != `EAU_A_DST_FC) &&
			(awaddr_r != `EAU_A_LAST_ADDR) && (awaddr_r != `EAU_A_STAT))
			bresp_nxt = `EAU_RESP_SLVERR;
	end

	always @*
	begin
		rresp_nxt = `EAU_RESP_OKAY;
		case (araddr_r)
			`EAU_A_SW: rd_nxt = {16'h0, status_word_r};
			`EAU_A_VEC_BASE: rd_nxt = vec_base_r;
			`EAU_A_SRC_FC: rd_nxt = {29'h0, src_fc_r};
			`EAU_A_DST_FC: rd_nxt = {29'h0, dst_fc_r};
			`EAU_A_LAST_ADDR: rd_nxt = eff_addr_r;
			`EAU_A_STAT: rd_nxt = {29'h0, st_r};
			default:
			begin
				rd_nxt = gpr_ok(araddr_r) ? rdata_a : 32'h00000000;
				rresp_nxt = gpr_ok(araddr_r) ? `EAU_RESP_OKAY : `EAU_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status_word_r <= `EAU_SW_RST;
			vec_base_r <= `EAU_VEC_BASE_RST;
			src_fc_r <= `EAU_FC_RST;
			dst_fc_r <= `EAU_FC_RST;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `EAU_RESP_OKAY;
			arready_r <= 1'b0;
			ar_hold_r <= 1'b0;
			rd_wait_r <= 1'b0;
			araddr_r <= 8'h00;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `EAU_RESP_OKAY;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			bvalid_r <= bvalid_nxt;
			awready_r <= !aw_hold_nxt && !bvalid_nxt;
			wready_r <= !w_hold_nxt && !bvalid_nxt;
			if (aw_take)
				awaddr_r <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				bresp_r <= bresp_nxt;
				if (awaddr_r == `EAU_A_SW)
				begin
					if (wstrb_r[0])
						status_word_r[7:0] <= wdata_r[7:0] & sw_mask[7:0];
					if (wstrb_r[1])
						status_word_r[15:8] <= wdata_r[15:8] & sw_mask[15:8];
				end
				if (awaddr_r == `EAU_A_VEC_BASE)
				begin
					if (wstrb_r[0])
						vec_base_r[7:0] <= wdata_r[7:0];
					if (wstrb_r[1])
						vec_base_r[15:8] <= wdata_r[15:8];
					if (wstrb_r[2])
						vec_base_r[23:16] <= wdata_r[23:16];
					if (wstrb_r[3])
						vec_base_r[31:24] <= wdata_r[31:24];
				end
				if ((awaddr_r == `EAU_A_SRC_FC) && wstrb_r[0])
					src_fc_r <= wdata_r[2:0];
				if ((awaddr_r == `EAU_A_DST_FC) && wstrb_r[0])
					dst_fc_r <= wdata_r[2:0];
			end
			ar_hold_r <= ar_hold_nxt;
			rd_wait_r <= rd_issue;
			rvalid_r <= rvalid_nxt;
			arready_r <= !ar_hold_nxt && !rvalid_nxt;
			if (s_axi_arvalid && arready_r)
				araddr_r <= s_axi_araddr;
			if (rd_wait_r)
			begin
				rdata_r <= rd_nxt;
				rresp_r <= rresp_nxt;
			end
		end
	end

	assign req_ready = req_ready_r;
	assign done = done_r;
	assign is_mem = is_mem_r;
	assign bad_mode = bad_mode_r;
	assign effective_address = eff_addr_r;
	assign operand = operand_r;
	assign status_word = status_word_r;
	assign vector_table_base = vec_base_r;
	assign source_alt_fn_code = src_fc_r;
	assign dest_alt_fn_code = dst_fc_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rvalid = rvalid_r;

endmodule // eau_unit

// >>> tb/eau_unit_checker.sv
`include "eau_defs.vh"

module eau_unit_checker (
	// Clock and reset
	input logic clk,
	input logic rst,
	// Decoder side
	input logic req_valid,
	input logic req_ready,
	input logic done,
	input logic is_mem,
	input logic [31:0] effective_address,
	// Control registers
	input logic [15:0] status_word,
	input logic [31:0] vector_table_base,
	// Register bus
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [1:0] s_axi_rresp,
	input logic [31:0] s_axi_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_done_latency: assert property ((req_valid && req_ready) |=> !done ##1 !done ##1 done)
		else $error("done not on third edge after take");
	a_busy_refuse: assert property ((req_valid && req_ready) |=> !req_ready [*2])
		else $error("request accepted while busy");
	a_ea_only_mem: assert property ($changed(effective_address) |-> done && is_mem)
		else $error("address moved without memory result");
	a_sw_bits: assert property ((status_word & ~`EAU_SW_MASK) == 16'h0000)
		else $error("reserved status bit set");
	a_ctrl_by_bus: assert property (($changed(status_word) || $changed(vector_table_base))
		|-> $rose(s_axi_bvalid))
		else $error("control register changed without bus write");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response dropped");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[2:4] s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[3:40] s_axi_rvalid)
		else $error("read response late");

	c_mem: cover property (done && is_mem);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `EAU_RESP_SLVERR);
	c_bstall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // eau_unit_checker

bind eau_unit eau_unit_checker u_chk (.*);

// >>> tb/eau_dec_model.sv
module eau_dec_model (
	// Clock
	input logic clk,
	// Request to the unit
	output logic req_valid,
	input logic req_ready,
	output logic [3:0] req_mode,
	output logic [2:0] req_reg,
	output logic [1:0] req_size,
	output logic [3:0] req_xsel,
	output logic req_xlong,
	output logic [15:0] req_ext0,
	output logic [15:0] req_ext1,
	output logic [31:0] req_pc,
	output logic [2:0] req_quick,
	output logic [2:0] req_impl,
	// Result from the unit
	input logic done,
	input logic is_mem,
	input logic bad_mode,
	input logic [31:0] effective_address,
	input logic [31:0] operand
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		req_valid = 1'b0;
		{req_mode, req_reg, req_size, req_xsel, req_xlong, req_quick, req_impl} = '0;
		{req_ext0, req_ext1, req_pc} = '0;
	end

	// Held until taken; quick and implied selects ride in bits 18:16 of e
	task automatic issue(input logic [3:0] m, input logic [2:0] r, input logic [1:0] sz,
		input logic [4:0] x, input logic [31:0] e, output logic [31:0] addr,
		output logic [31:0] op, output logic mem, output logic bad, output logic ok);
		int n;
		n = 0;
		req_valid <= 1'b1;
		{req_mode, req_reg, req_size, req_xlong, req_xsel} <= {m, r, sz, x};
		{req_ext0, req_ext1, req_pc, req_quick, req_impl} <= {e, 32'h00010000, e[18:16], e[18:16]};
		do
			@(posedge clk);
		while (!req_ready && n++ < 40);
		// Released lines flip so a late sample cannot match by luck
		req_valid <= 1'b0;
		{req_ext0, req_ext1, req_pc} <= ~{e, 32'h00010000};
		do
			@(posedge clk);
		while (!done && n++ < 80);
		addr = effective_address;
		op = operand;
		mem = is_mem;
		bad = bad_mode;
		ok = done;
	endtask
endmodule // eau_dec_model

// >>> tb/effective_address_unit_tb.sv
module effective_address_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, req_valid, req_ready, req_xlong, done, is_mem, bad_mode, stall;
	logic [3:0] req_mode, req_xsel, s_axi_wstrb;
	logic [2:0] req_reg, req_quick, req_impl, source_alt_fn_code, dest_alt_fn_code;
	logic [1:0] req_size, s_axi_bresp, s_axi_rresp;
	logic [15:0] req_ext0, req_ext1, status_word;
	logic [31:0] req_pc, effective_address, operand, vector_table_base, s_axi_wdata, s_axi_rdata;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem, bad, ok;
	logic [31:0] addr_got, op, impl_exp [7];
	int err_total, n_checks;

	eau_unit u_dut (.*);
	eau_dec_model u_dec (.*);

	always #2 clk = ~clk;

	task automatic final_report(input logic hung);
		if (hung)
			err_total++;
		if (err_total == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		n = 0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, !stall};
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (n == 3 && !s_axi_bready)
				s_axi_bready <= 1'b1;
		end
		while (!(s_axi_bvalid && s_axi_bready) && n++ < 40);
		if (!s_axi_bvalid)
			final_report(1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, !stall};
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (n == 3 && !s_axi_rready)
				s_axi_rready <= 1'b1;
		end
		while (!(s_axi_rvalid && s_axi_rready) && n++ < 40);
		if (!s_axi_rvalid)
			final_report(1);
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] ev);
		axi_wr(a, d, s, 2'h0);
		axi_rd(a, ev, 2'h0);
	endtask

	task automatic run(input logic [3:0] m, input logic [2:0] r, input logic [1:0] sz,
		input logic [4:0] x, input logic [31:0] e, input logic em, input logic [31:0] ev);
		u_dec.issue(m, r, sz, x, e, addr_got, op, mem, bad, ok);
		if (!ok)
			final_report(1);
		chk({30'h0, bad, mem}, {31'h0, em});
		chk(em ? addr_got : op, ev);
	endtask

	initial
	begin
		{clk, rst, stall, err_total, n_checks} = {3'b010, 32'h0, 32'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		impl_exp = '{32'ha71f, 32'h3000, 32'h2002, 32'h10000, 32'h12345678, 32'h5, 32'h2};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		axi_rd(8'h00, 32'h2700, 2'h0);
		axi_rd(8'h04, 32'h0, 2'h0);
		axi_rd(8'h08, 32'h0, 2'h0);
		for (int i = 0; i < 17; i++)
		begin
			axi_rd(8'h80 + 8'(4 * i), 32'h0, 2'h0);
			wrd(8'h80 + 8'(4 * i), {24'h5a5a00, 8'(i)}, 4'hf, {24'h5a5a00, 8'(i)});
		end
		stall = 1'b1;
		wrd(8'h00, 32'hffffffff, 4'hf, 32'ha71f);
		wrd(8'h04, 32'h12345678, 4'hf, 32'h12345678);
		wrd(8'h08, 32'hfffffffd, 4'hf, 32'h5);
		wrd(8'h0c, 32'h2, 4'hf, 32'h2);
		chk({10'h0, status_word, source_alt_fn_code, dest_alt_fn_code}, 32'h29c7ea);
		chk(vector_table_base, 32'h12345678);
		stall = 1'b0;
		axi_wr(8'h18, 32'h1, 4'hf, 2'h2);
		axi_rd(8'h18, 32'h0, 2'h2);
		wrd(8'h84, 32'haa, 4'h1, 32'h5a5a00aa);
		wrd(8'h84, 32'hbeef, 4'h3, 32'h5a5abeef);
		axi_wr(8'hac, 32'haa, 4'h1, 2'h2);
		axi_rd(8'hac, 32'h5a5a000b, 2'h0);
		wrd(8'hac, 32'h8000, 4'h3, 32'hffff8000);
		wrd(8'h80, 32'h10, 4'hf, 32'h10);
		wrd(8'ha8, 32'h1000, 4'hf, 32'h1000);
		wrd(8'hbc, 32'h3000, 4'hf, 32'h3000);
		wrd(8'hc0, 32'h2000, 4'hf, 32'h2000);
		run(4'h0, 3'h0, 2'h2, 5'h0, 32'h0, 1'b0, 32'h10);
		run(4'h1, 3'h2, 2'h2, 5'h0, 32'h0, 1'b0, 32'h1000);
		run(4'h2, 3'h2, 2'h2, 5'h0, 32'h0, 1'b1, 32'h1000);
		run(4'h5, 3'h2, 2'h1, 5'h0, 32'hfffe0000, 1'b1, 32'h0ffe);
		run(4'h6, 3'h2, 2'h1, 5'h10, 32'h00040000, 1'b1, 32'h1014);
		run(4'h6, 3'h2, 2'h1, 5'h0f, 32'h00fc0000, 1'b1, 32'h2ffc);
		run(4'h3, 3'h2, 2'h2, 5'h0, 32'h0, 1'b1, 32'h1000);
		axi_rd(8'ha8, 32'h1004, 2'h0);
		run(4'h4, 3'h2, 2'h1, 5'h0, 32'h0, 1'b1, 32'h1002);
		run(4'h4, 3'h2, 2'h0, 5'h0, 32'h0, 1'b1, 32'h1001);
		axi_rd(8'ha8, 32'h1001, 2'h0);
		run(4'h3, 3'h7, 2'h0, 5'h0, 32'h0, 1'b1, 32'h2000);
		axi_rd(8'hc0, 32'h2002, 2'h0);
		run(4'h7, 3'h0, 2'h1, 5'h0, 32'h12340000, 1'b1, 32'h1234);
		run(4'h8, 3'h0, 2'h2, 5'h0, 32'h00abcdef, 1'b1, 32'h00abcdef);
		run(4'h9, 3'h0, 2'h1, 5'h0, 32'hfff00000, 1'b1, 32'hfff0);
		run(4'ha, 3'h0, 2'h1, 5'h10, 32'h12fe0000, 1'b1, 32'h1000e);
		run(4'hb, 3'h0, 2'h2, 5'h0, 32'hdeadbeef, 1'b0, 32'hdeadbeef);
		run(4'hb, 3'h0, 2'h1, 5'h0, 32'h12340000, 1'b0, 32'h1234);
		run(4'hc, 3'h0, 2'h2, 5'h0, 32'h0, 1'b0, 32'h8);
		run(4'hc, 3'h0, 2'h2, 5'h0, 32'h00030000, 1'b0, 32'h3);
		axi_wr(8'h10, 32'h1, 4'hf, 2'h0);
		axi_rd(8'h10, 32'h1000e, 2'h0);
		axi_wr(8'h80, 32'h1, 4'h2, 2'h2);
		u_dec.issue(4'he, 3'h0, 2'h2, 5'h0, 32'h0, addr_got, op, mem, bad, ok);
		if (!ok)
			final_report(1);
		chk({31'h0, bad}, 32'h1);
		for (int i = 0; i < 7; i++)
			run(4'hd, 3'h0, 2'h2, 5'h0, {13'h0, 3'(i), 16'h0}, 1'b0, impl_exp[i]);
		u_dec.issue(4'hd, 3'h0, 2'h2, 5'h0, 32'h00070000, addr_got, op, mem, bad, ok);
		chk({31'h0, bad}, 32'h1);
		final_report(!ok);
	end
endmodule // effective_address_unit_tb
